// *** include/mcr_pkg.sv ***
`default_nettype none
package mcr_pkg;
  localparam logic [7:0] ST_OK        = 8'h64;
  localparam logic [7:0] ST_STORED    = 8'h65;
  localparam logic [7:0] ST_BAD_SUM   = 8'h01;
  localparam logic [7:0] ST_BAD_CMD   = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE  = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_LOCKED    = 8'h05;
  localparam logic [7:0] ST_NOT_AVAIL = 8'h06;

  localparam logic [7:0] CMD_ROT_RIGHT  = 8'h01;
  localparam logic [7:0] CMD_ROT_LEFT   = 8'h02;
  localparam logic [7:0] CMD_STOP_MOTOR = 8'h03;
  localparam logic [7:0] CMD_MOVE       = 8'h04;
  localparam logic [7:0] CMD_WR_AXIS    = 8'h05;
  localparam logic [7:0] CMD_RD_AXIS    = 8'h06;
  localparam logic [7:0] CMD_WR_MOD     = 8'h09;
  localparam logic [7:0] CMD_RD_MOD     = 8'h0A;
  localparam logic [7:0] CMD_PERSIST    = 8'h0B;
  localparam logic [7:0] CMD_RELOAD     = 8'h0C;
  localparam logic [7:0] CMD_DRIVE_OUT  = 8'h0E;
  localparam logic [7:0] CMD_SAMPLE_IN  = 8'h0F;
  localparam logic [7:0] CMD_ARITHMETIC_WITH_CONSTANT       = 8'h13;
  localparam logic [7:0] CMD_COMPARE    = 8'h14;
  localparam logic [7:0] CMD_BRANCH_IF  = 8'h15;
  localparam logic [7:0] CMD_BRANCH     = 8'h16;
  localparam logic [7:0] CMD_WAIT       = 8'h1B;
  localparam logic [7:0] CMD_ARITHMETIC_WITH_X_REGISTER      = 8'h21;
  localparam logic [7:0] CMD_ACC_AXIS   = 8'h22;
  localparam logic [7:0] CMD_ACC_MOD    = 8'h23;
  localparam logic [7:0] CMD_CLR_ERR    = 8'h24;

  // Byte positions of command frames (POS_) and reply frames (RP_); value and checksum positions serve both.
  localparam logic [3:0] POS_ADDR    = 4'h0;
  localparam logic [3:0] POS_CMD     = 4'h1;
  localparam logic [3:0] POS_TYPE    = 4'h2;
  localparam logic [3:0] POS_BANK    = 4'h3;
  localparam logic [3:0] POS_VAL     = 4'h4;
  localparam logic [3:0] POS_SUM     = 4'h8;
  localparam logic [3:0] POS_LAST_CAN = 4'h7;
  localparam logic [3:0] RP_RADDR    = 4'h0;
  localparam logic [3:0] RP_MADDR    = 4'h1;
  localparam logic [3:0] RP_STATUS   = 4'h2;
  localparam logic [3:0] RP_CMD      = 4'h3;

  localparam logic [7:0] OP_ADD  = 8'h00;
  localparam logic [7:0] OP_SUB  = 8'h01;
  localparam logic [7:0] OP_MUL  = 8'h02;
  localparam logic [7:0] OP_AND  = 8'h05;
  localparam logic [7:0] OP_OR   = 8'h06;
  localparam logic [7:0] OP_XOR  = 8'h07;
  localparam logic [7:0] OP_NOT  = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;
  localparam logic [7:0] OP_TO_X = 8'h0A;

  localparam logic [7:0] TMAX_ANY   = 8'hFF;
  localparam logic [7:0] TMAX_MOVE  = 8'h02;
  localparam logic [7:0] TMAX_ARITHMETIC_WITH_CONSTANT  = 8'h09;
  localparam logic [7:0] TMAX_ARITHMETIC_WITH_X_REGISTER = 8'h0A;
  localparam logic [7:0] TMAX_ERR   = 8'h03;
  localparam logic [7:0] TMAX_ZERO  = 8'h00;
  localparam logic [7:0] AXIS_LAST  = 8'h00;
  localparam logic [7:0] USER_BANK  = 8'h02;
  localparam logic [31:0] BIN_MAX   = 32'h0000_0001;

  typedef enum logic [2:0] {
    CL_BAD, CL_EXEC, CL_ARITHMETIC_WITH_CONSTANT, CL_ARITHMETIC_WITH_X_REGISTER, CL_COMP, CL_PROG, CL_CLEAR
  } mcr_class_type;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } mcr_cmd_type;

  typedef struct packed {
    mcr_class_type cls;
    logic          reads;
    logic          locked_by_cfg;
    logic          user_only;
    logic          axis;
    logic          bin_value;
    logic          use_accu;
    logic [7:0]    type_max;
  } mcr_dec_type;

  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] value;
  } mcr_result_type;
endpackage
`default_nettype wire

// *** core/mcr_cmd_decode.sv ***
`default_nettype none
module mcr_cmd_decode
  import mcr_pkg::*;
(
  // Command number
  input  wire logic [7:0] cmd_i,
  // Decoded attributes
  output mcr_dec_type     dec_o
);
  always_comb
  begin
    dec_o = '{cls: CL_BAD, reads: 1'b0, locked_by_cfg: 1'b0, user_only: 1'b0,
              axis: 1'b0, bin_value: 1'b0, use_accu: 1'b0, type_max: TMAX_ZERO};
    case (cmd_i)
      CMD_ROT_RIGHT, CMD_ROT_LEFT, CMD_STOP_MOTOR:
      begin
        dec_o.cls  = CL_EXEC;
        dec_o.axis = 1'b1;
      end
      CMD_MOVE:
      begin
        dec_o.cls      = CL_EXEC;
        dec_o.axis     = 1'b1;
        dec_o.type_max = TMAX_MOVE;
      end
      CMD_WR_AXIS, CMD_RD_AXIS:
      begin
        dec_o.cls      = CL_EXEC;
        dec_o.axis     = 1'b1;
        dec_o.reads    = (cmd_i == CMD_RD_AXIS);
        dec_o.type_max = TMAX_ANY;
      end
      CMD_WR_MOD, CMD_RD_MOD:
      begin
        dec_o.cls           = CL_EXEC;
        dec_o.reads         = (cmd_i == CMD_RD_MOD);
        dec_o.locked_by_cfg = (cmd_i == CMD_WR_MOD);
        dec_o.type_max      = TMAX_ANY;
      end
      CMD_PERSIST, CMD_RELOAD:
      begin
        dec_o.cls           = CL_EXEC;
        dec_o.user_only     = 1'b1;
        dec_o.locked_by_cfg = (cmd_i == CMD_PERSIST);
        dec_o.type_max      = TMAX_ANY;
      end
      CMD_DRIVE_OUT, CMD_SAMPLE_IN:
      begin
        dec_o.cls       = CL_EXEC;
        dec_o.reads     = (cmd_i == CMD_SAMPLE_IN);
        dec_o.bin_value = (cmd_i == CMD_DRIVE_OUT);
        dec_o.type_max  = TMAX_ANY;
      end
      CMD_ARITHMETIC_WITH_CONSTANT:
      begin
        dec_o.cls      = CL_ARITHMETIC_WITH_CONSTANT;
        dec_o.type_max = TMAX_ARITHMETIC_WITH_CONSTANT;
      end
      CMD_ARITHMETIC_WITH_X_REGISTER:
      begin
        dec_o.cls      = CL_ARITHMETIC_WITH_X_REGISTER;
        dec_o.type_max = TMAX_ARITHMETIC_WITH_X_REGISTER;
      end
      CMD_COMPARE:
      begin
        dec_o.cls = CL_COMP;
      end
      CMD_BRANCH_IF, CMD_BRANCH, CMD_WAIT:
      begin
        dec_o.cls      = CL_PROG;
        dec_o.type_max = TMAX_ANY;
      end
      CMD_ACC_AXIS, CMD_ACC_MOD:
      begin
        dec_o.cls           = CL_EXEC;
        dec_o.axis          = (cmd_i == CMD_ACC_AXIS);
        dec_o.locked_by_cfg = (cmd_i == CMD_ACC_MOD);
        dec_o.use_accu      = 1'b1;
        dec_o.type_max      = TMAX_ANY;
      end
      CMD_CLR_ERR:
      begin
        dec_o.cls      = CL_CLEAR;
        dec_o.type_max = TMAX_ERR;
      end
      default:
      begin
        dec_o.cls = CL_BAD;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** core/mcr_engine.sv ***
`default_nettype none
module mcr_engine
  import mcr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Configuration
  input  wire logic [7:0]  module_addr_i,
  input  wire logic [7:0]  reply_addr_i,
  input  wire logic        can_mode_i,
  input  wire logic        store_mode_i,
  input  wire logic        cfg_lock_i,
  // Command bytes from the link
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  output logic             rx_ready_o,
  // Reply bytes to the link
  output logic             tx_valid_o,
  output logic [7:0]       tx_byte_o,
  input  wire logic        tx_ready_i,
  output logic [7:0]       tx_can_id_o,
  // Motion and parameter back end
  output logic             exec_valid_o,
  output logic             prog_wr_o,
  output mcr_cmd_type      exec_cmd_o,
  input  wire logic        exec_done_i,
  input  wire mcr_result_type exec_result_i,
  // Calculation state and error flags
  input  wire logic [3:0]  err_set_i,
  output logic [3:0]       err_flags_o,
  output logic [31:0]      accu_o,
  output logic [31:0]      xreg_o,
  output logic             flag_zero_o,
  output logic             flag_neg_o
);
  typedef enum logic [2:0] {
    S_RECV, S_CHECK, S_WAIT, S_REPLY
  } mcr_state_type;

  typedef struct packed {
    mcr_state_type   st;
    logic            can;
    logic [3:0]      cnt;
    logic [8:0][7:0] frame;
    logic [7:0]      sum;
    mcr_cmd_type     cmd;
    logic            reads;
    logic [7:0]      status;
    logic [31:0]     rvalue;
    logic [7:0]      tx_byte;
    logic [7:0]      can_id;
    logic [31:0]     accu;
    logic [31:0]     xreg;
    logic            flag_zero;
    logic            flag_neg;
    logic [3:0]      err;
    logic            exec_valid;
    logic            prog_wr;
  } mcr_regs_type;

  mcr_regs_type  regs_r;
  mcr_regs_type  regs_nxt;
  mcr_dec_type   dec;
  mcr_cmd_type   rx_cmd;
  logic          can_now;
  logic [3:0]    pos;
  logic [3:0]    pos_last;
  logic [7:0]    chk_status;
  logic [31:0]   arithmetic_with_constant_b;
  logic [31:0]   arithmetic_with_constant_res;
  logic [63:0]   prod;
  logic          arithmetic_with_constant_ok;
  logic [3:0]    clr_mask;
  logic [31:0]   cmp_diff;
  logic [7:0]    tx_sum;

  mcr_cmd_decode u_decode (
    .cmd_i (regs_r.frame[POS_CMD]),
    .dec_o (dec)
  );

  // The link mode is sampled only at the first byte, so a change in
  // mid-frame cannot shift byte positions.
  assign can_now  = (regs_r.st == S_RECV && regs_r.cnt == 4'h0) ? can_mode_i : regs_r.can;
  assign pos      = regs_r.cnt + {3'h0, can_now};
  assign pos_last = can_now ? POS_LAST_CAN : POS_SUM;

  assign rx_cmd = '{cmd:   regs_r.frame[POS_CMD],
                    typ:   regs_r.frame[POS_TYPE],
                    bank:  regs_r.frame[POS_BANK],
                    value: {regs_r.frame[POS_VAL], regs_r.frame[POS_VAL + 4'h1],
                            regs_r.frame[POS_VAL + 4'h2], regs_r.frame[POS_VAL + 4'h3]}};

  // Checks run in a fixed order so exactly one status is reported.
  always_comb
  begin
    chk_status = ST_OK;
    if (!regs_r.can && regs_r.sum != regs_r.frame[POS_SUM])
    begin
      chk_status = ST_BAD_SUM;
    end
    else if (dec.cls == CL_BAD)
    begin
      chk_status = ST_BAD_CMD;
    end
    else if (rx_cmd.typ > dec.type_max)
    begin
      chk_status = ST_BAD_TYPE;
    end
    else if ((dec.axis && rx_cmd.bank > AXIS_LAST) ||
             (dec.bin_value && rx_cmd.value > BIN_MAX) ||
             (dec.user_only && rx_cmd.bank != USER_BANK))
    begin
      chk_status = ST_BAD_VALUE;
    end
    else if (dec.locked_by_cfg && cfg_lock_i)
    begin
      chk_status = ST_LOCKED;
    end
    else if (store_mode_i)
    begin
      chk_status = ST_STORED;
    end
    else if (dec.cls == CL_PROG || (dec.cls inside {CL_ARITHMETIC_WITH_CONSTANT, CL_ARITHMETIC_WITH_X_REGISTER} && !arithmetic_with_constant_ok))
    begin
      chk_status = ST_NOT_AVAIL;
    end
  end

  assign arithmetic_with_constant_b = (dec.cls == CL_ARITHMETIC_WITH_CONSTANT) ? rx_cmd.value : regs_r.xreg;
  assign prod   = {32'h0, regs_r.accu} * {32'h0, arithmetic_with_constant_b};

  // Division and modulo are not built; they answer as not available.
  always_comb
  begin
    arithmetic_with_constant_ok  = 1'b1;
    arithmetic_with_constant_res = regs_r.accu;
    case (rx_cmd.typ)
      OP_ADD:  arithmetic_with_constant_res = regs_r.accu + arithmetic_with_constant_b;
      OP_SUB:  arithmetic_with_constant_res = regs_r.accu - arithmetic_with_constant_b;
      OP_MUL:  arithmetic_with_constant_res = prod[31:0];
      OP_AND:  arithmetic_with_constant_res = regs_r.accu & arithmetic_with_constant_b;
      OP_OR:   arithmetic_with_constant_res = regs_r.accu | arithmetic_with_constant_b;
      OP_XOR:  arithmetic_with_constant_res = regs_r.accu ^ arithmetic_with_constant_b;
      OP_NOT:  arithmetic_with_constant_res = ~regs_r.accu;
      OP_LOAD: arithmetic_with_constant_res = arithmetic_with_constant_b;
      OP_TO_X: arithmetic_with_constant_res = regs_r.accu;
      default: arithmetic_with_constant_ok  = 1'b0;
    endcase
  end

  assign cmp_diff = regs_r.accu - rx_cmd.value;
  assign tx_sum   = regs_r.sum + regs_r.tx_byte;

  function automatic logic [7:0] reply_byte(input logic [3:0]   p,
                                            input mcr_regs_type q,
                                            input logic [7:0]   maddr,
                                            input logic [7:0]   raddr,
                                            input logic [7:0]   s);
    logic [7:0] b;
    b = s;
    case (p)
      RP_RADDR:         b = raddr;
      RP_MADDR:         b = maddr;
      RP_STATUS:        b = q.status;
      RP_CMD:           b = q.cmd.cmd;
      POS_VAL:          b = q.rvalue[31:24];
      POS_VAL + 4'h1:   b = q.rvalue[23:16];
      POS_VAL + 4'h2:   b = q.rvalue[15:8];
      POS_VAL + 4'h3:   b = q.rvalue[7:0];
      default:          b = s;
    endcase
    return b;
  endfunction

  always_comb
  begin
    clr_mask = 4'h0;
    if (regs_r.st == S_CHECK && dec.cls == CL_CLEAR && chk_status == ST_OK)
    begin
      clr_mask[rx_cmd.typ[1:0]] = 1'b1;
    end
  end

  always_comb
  begin
    regs_nxt            = regs_r;
    regs_nxt.exec_valid = 1'b0;
    regs_nxt.prog_wr    = 1'b0;
    // A flag raised in the cycle it is cleared stays raised.
    regs_nxt.err        = (regs_r.err & ~clr_mask) | err_set_i;
    case (regs_r.st)
      S_RECV:
      begin
        if (rx_valid_i)
        begin
          regs_nxt.can        = can_now;
          regs_nxt.frame[pos] = rx_byte_i;
          if (regs_r.cnt == 4'h0)
          begin
            regs_nxt.sum = rx_byte_i;
          end
          else if (pos != POS_SUM)
          begin
            regs_nxt.sum = regs_r.sum + rx_byte_i;
          end
          if (pos == pos_last)
          begin
            regs_nxt.st  = S_CHECK;
            regs_nxt.cnt = 4'h0;
          end
          else
          begin
            regs_nxt.cnt = regs_r.cnt + 4'h1;
          end
        end
      end
      S_CHECK:
      begin
        regs_nxt.cmd    = rx_cmd;
        regs_nxt.reads  = dec.reads;
        regs_nxt.status = chk_status;
        regs_nxt.rvalue = rx_cmd.value;
        regs_nxt.can_id = reply_addr_i;
        if (!regs_r.can && regs_r.frame[POS_ADDR] != module_addr_i)
        begin
          regs_nxt.st = S_RECV;
        end
        else
        begin
          regs_nxt.st = S_REPLY;
          if (chk_status == ST_STORED)
          begin
            regs_nxt.prog_wr = 1'b1;
          end
          else if (chk_status == ST_OK)
          begin
            case (dec.cls)
              CL_EXEC:
              begin
                if (dec.use_accu)
                begin
                  regs_nxt.cmd.value = regs_r.accu;
                end
                regs_nxt.exec_valid = 1'b1;
                regs_nxt.st         = S_WAIT;
              end
              CL_ARITHMETIC_WITH_CONSTANT, CL_ARITHMETIC_WITH_X_REGISTER:
              begin
                if (dec.cls == CL_ARITHMETIC_WITH_X_REGISTER && rx_cmd.typ == OP_TO_X)
                begin
                  regs_nxt.xreg = regs_r.accu;
                end
                else
                begin
                  regs_nxt.accu = arithmetic_with_constant_res;
                end
              end
              CL_COMP:
              begin
                regs_nxt.flag_zero = (cmp_diff == 32'h0);
                regs_nxt.flag_neg  = ($signed(regs_r.accu) < $signed(rx_cmd.value));
              end
              default:
              begin
                regs_nxt.status = chk_status;
              end
            endcase
          end
        end
        if (regs_nxt.st == S_REPLY)
        begin
          regs_nxt.sum     = 8'h00;
          regs_nxt.cnt     = 4'h0;
          regs_nxt.tx_byte = reply_byte(regs_r.can ? RP_MADDR : RP_RADDR, regs_nxt,
                                        module_addr_i, reply_addr_i, 8'h00);
        end
      end
      S_WAIT:
      begin
        if (exec_done_i)
        begin
          regs_nxt.status = exec_result_i.status;
          if (regs_r.reads)
          begin
            regs_nxt.rvalue = exec_result_i.value;
          end
          regs_nxt.st      = S_REPLY;
          regs_nxt.sum     = 8'h00;
          regs_nxt.cnt     = 4'h0;
          regs_nxt.tx_byte = reply_byte(regs_r.can ? RP_MADDR : RP_RADDR, regs_nxt,
                                        module_addr_i, reply_addr_i, 8'h00);
        end
      end
      S_REPLY:
      begin
        if (tx_ready_i)
        begin
          regs_nxt.sum = tx_sum;
          if (pos == pos_last)
          begin
            regs_nxt.st  = S_RECV;
            regs_nxt.cnt = 4'h0;
          end
          else
          begin
            regs_nxt.cnt     = regs_r.cnt + 4'h1;
            regs_nxt.tx_byte = reply_byte(pos + 4'h1, regs_r, module_addr_i,
                                          reply_addr_i, tx_sum);
          end
        end
      end
      default:
      begin
        regs_nxt.st  = S_RECV;
        regs_nxt.cnt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      regs_r <= '0;
    end
    else
    begin
      regs_r <= regs_nxt;
    end
  end

  // Bytes are only accepted while idle; the host must wait for the reply.
  assign rx_ready_o   = (regs_r.st == S_RECV);
  assign tx_valid_o   = (regs_r.st == S_REPLY);
  assign tx_byte_o    = regs_r.tx_byte;
  assign tx_can_id_o  = regs_r.can_id;
  assign exec_valid_o = regs_r.exec_valid;
  assign prog_wr_o    = regs_r.prog_wr;
  assign exec_cmd_o   = regs_r.cmd;
  assign err_flags_o  = regs_r.err;
  assign accu_o       = regs_r.accu;
  assign xreg_o       = regs_r.xreg;
  assign flag_zero_o  = regs_r.flag_zero;
  assign flag_neg_o   = regs_r.flag_neg;
endmodule
`default_nettype wire

// *** bench/mcr_engine_monitor.sv ***
`default_nettype none
module mcr_engine_monitor
  import mcr_pkg::*;
(
  // Clock, reset and configuration
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic [7:0] module_addr_i,
  input wire logic [7:0] reply_addr_i,
  input wire logic       can_mode_i,
  // Link and back end
  input wire logic       rx_ready_o,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic       tx_ready_i,
  input wire logic       exec_valid_o,
  input wire logic       exec_done_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic [7:0] sum_r;
  logic       can_r;

  // Bytes taken and their running sum within the reply now being sent.
  // The link mode is frozen when receiving stops, because the bench may
  // switch modes in the very cycle that the last reply byte is taken.
  always_ff @(posedge clk_i)
  begin
    if (srst_i || rx_ready_o)
    begin
      cnt_r <= 4'h0;
      sum_r <= 8'h00;
      can_r <= can_mode_i;
    end
    else if (tx_valid_o && tx_ready_i)
    begin
      cnt_r <= cnt_r + 4'h1;
      sum_r <= sum_r + tx_byte_o;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_byte_held: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("reply byte changed before it was taken");
  a_quiet_listen: assert property (
    rx_ready_o |-> !tx_valid_o)
    else $error("reply byte offered while receiving");
  a_exec_pulse: assert property (
    exec_valid_o |=> !exec_valid_o && !rx_ready_o)
    else $error("back end request not a single pulse");
  a_done_reply: assert property (
    exec_valid_o ##1 exec_done_i |=> tx_valid_o)
    else $error("no reply the cycle after back end done");
  a_reply_lead: assert property (
    $rose(tx_valid_o) && !can_mode_i |-> tx_byte_o == reply_addr_i)
    else $error("serial reply does not start with reply address");
  a_can_lead: assert property (
    $rose(tx_valid_o) && can_mode_i |-> tx_byte_o == module_addr_i)
    else $error("CAN reply does not start with module address");
  a_reply_len: assert property (
    $rose(rx_ready_o) |-> cnt_r == 4'h0 || cnt_r == (can_r ? 4'h7 : 4'h9))
    else $error("reply length wrong");
  a_sum_last: assert property (
    tx_valid_o && tx_ready_i && !can_r && cnt_r == 4'h8 |-> tx_byte_o == sum_r)
    else $error("reply checksum wrong");
endmodule
`default_nettype wire

// *** bench/mcr_host.sv ***
`default_nettype none
module mcr_host
  import mcr_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Command bytes towards the engine
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_byte_o,
  input  wire logic       cmd_ready_i,
  // Reply bytes from the engine
  input  wire logic       rep_valid_i,
  input  wire logic [7:0] rep_byte_i,
  output logic            rep_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rep [9];
  int         nrep;
  bit         slow;
  bit         hung;

  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_byte_o  = 8'h5A;
    rep_ready_o = 1'b1;
    slow        = 1'b0;
    hung        = 1'b0;
  end

  // Bytes go out in frame order, each held until the engine takes it.
  task automatic send(input logic [7:0] f [9], input int lo, input int hi);
    int k;
    for (int i = lo; i < hi; i++)
    begin
      cmd_valid_o <= 1'b1;
      cmd_byte_o  <= f[i];
      k = 0;
      do
      begin
        @(posedge clk_i);
        k++;
      end
      while (!cmd_ready_i && k < 200);
      hung |= (k == 200);
    end
    cmd_valid_o <= 1'b0;
    // A released line must not look like a repeat of the last byte.
    cmd_byte_o  <= ~f[hi-1];
  endtask

  // The caller sends nothing new until this returns with the whole reply.
  task automatic collect(input int n);
    int k;
    nrep = 0;
    k = 0;
    while (nrep < n && k < 400)
    begin
      @(posedge clk_i);
      k++;
      if (rep_valid_i && rep_ready_o)
      begin
        rep[nrep] = rep_byte_i;
        nrep++;
      end
      rep_ready_o <= !slow || k[0];
    end
    hung |= (k == 400);
  endtask
endmodule
`default_nettype wire

// *** bench/mcr_engine_tb.sv ***
`default_nettype none
module mcr_engine_tb
  import mcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MY_ADDR = 8'h3C;
  logic           clk_i, srst_i, can_mode_i, store_mode_i, cfg_lock_i;
  logic           rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, exec_valid_o;
  logic           prog_wr_o, exec_done_i, flag_zero_o, flag_neg_o;
  logic [7:0]     module_addr_i, reply_addr_i, rx_byte_i, tx_byte_o, tx_can_id_o;
  logic [7:0]     addr_sel, sum_err;
  logic [7:0]     fr [9];
  logic [3:0]     err_set_i, err_flags_o;
  logic [31:0]    accu_o, xreg_o;
  mcr_cmd_type    exec_cmd_o, ex_seen;
  mcr_result_type be_res;
  int             be_lat, be_cnt, prog_cnt, error_cnt, checked;

  mcr_engine u_mcr_engine (
    .clk_i(clk_i), .srst_i(srst_i), .module_addr_i(module_addr_i),
    .reply_addr_i(reply_addr_i), .can_mode_i(can_mode_i), .store_mode_i(store_mode_i),
    .cfg_lock_i(cfg_lock_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
    .tx_ready_i(tx_ready_i), .tx_can_id_o(tx_can_id_o), .exec_valid_o(exec_valid_o),
    .prog_wr_o(prog_wr_o), .exec_cmd_o(exec_cmd_o), .exec_done_i(exec_done_i),
    .exec_result_i(be_res), .err_set_i(err_set_i), .err_flags_o(err_flags_o),
    .accu_o(accu_o), .xreg_o(xreg_o), .flag_zero_o(flag_zero_o), .flag_neg_o(flag_neg_o));

  mcr_host u_mcr_host (
    .clk_i(clk_i), .cmd_valid_o(rx_valid_i), .cmd_byte_o(rx_byte_i),
    .cmd_ready_i(rx_ready_o), .rep_valid_i(tx_valid_o), .rep_byte_i(tx_byte_o),
    .rep_ready_o(tx_ready_i));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Back end answers after be_lat idle cycles; zero means the cycle after the request.
  always @(posedge clk_i)
  begin
    prog_cnt    <= prog_cnt + int'(prog_wr_o);
    exec_done_i <= exec_valid_o ? (be_lat == 0) : (be_cnt == 1);
    if (exec_valid_o)
    begin
      ex_seen <= exec_cmd_o;
      be_cnt  <= be_lat;
    end
    else if (be_cnt != 0)
      be_cnt <= be_cnt - 1;
  end

  always @(posedge clk_i)
    if (u_mcr_host.hung)
    begin
      error_cnt++;
      report_and_stop();
    end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic xact(input logic [7:0] c, t, b, input logic [31:0] v, input bit want);
    fr = '{addr_sel, c, t, b, v[31:24], v[23:16], v[15:8], v[7:0], sum_err};
    for (int i = 0; i < 8; i++)
      fr[8] += fr[i];
    if (can_mode_i)
      u_mcr_host.send(fr, 1, 8);
    else
      u_mcr_host.send(fr, 0, 9);
    if (want)
      u_mcr_host.collect(can_mode_i ? 7 : 9);
  endtask

  task automatic chk_rep(input logic [7:0] st, c, input logic [31:0] v);
    logic [7:0] e [9];
    e = '{reply_addr_i, module_addr_i, st, c, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++)
      e[8] += e[i];
    for (int i = can_mode_i; i < (can_mode_i ? 8 : 9); i++)
      chk(u_mcr_host.rep[i - can_mode_i], e[i]);
    chk(u_mcr_host.nrep, can_mode_i ? 7 : 9);
  endtask

  task automatic t_backend();
    logic [7:0]  cl [11] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0A, 8'h0B,
                             8'h0C, 8'h0E, 8'h0F};
    logic [31:0] ev;
    for (int i = 0; i < 11; i++)
    begin
      be_lat = i % 3;
      u_mcr_host.slow = i[0];
      xact(cl[i], 8'h00, (cl[i] inside {8'h0B, 8'h0C}) ? 8'h02 : 8'h00, 32'h1, 1'b1);
      ev = (cl[i] inside {8'h06, 8'h0A, 8'h0F}) ? be_res.value : 32'h1;
      chk_rep(ST_OK, cl[i], ev);
      chk(ex_seen.cmd, cl[i]);
    end
    u_mcr_host.slow = 1'b0;
  endtask

  task automatic t_errors();
    logic [31:0] row [11] = '{32'h01000002, 32'h07000000, 32'h01010000, 32'h05000100,
      32'h0E000000, 32'h09000001, 32'h16000000, 32'h15000000, 32'h1B000000, 32'h13030000,
      32'h21030000};
    logic [7:0]  st [11] = '{ST_BAD_SUM, ST_BAD_CMD, ST_BAD_TYPE, ST_BAD_VALUE, ST_BAD_VALUE,
      ST_LOCKED, ST_NOT_AVAIL, ST_NOT_AVAIL, ST_NOT_AVAIL, ST_NOT_AVAIL, ST_NOT_AVAIL};
    for (int i = 0; i < 11; i++)
    begin
      cfg_lock_i <= row[i][0];
      sum_err = {7'h00, row[i][1]};
      xact(row[i][31:24], row[i][23:16], row[i][15:8], 32'h2, 1'b1);
      chk(u_mcr_host.rep[2], st[i]);
      chk(u_mcr_host.rep[3], row[i][31:24]);
    end
    cfg_lock_i <= 1'b0;
    sum_err = 8'h00;
  endtask

  task automatic t_store();
    int p;
    p = prog_cnt;
    store_mode_i <= 1'b1;
    xact(CMD_ROT_RIGHT, 8'h00, 8'h00, 32'h40, 1'b1);
    chk_rep(ST_STORED, CMD_ROT_RIGHT, 32'h40);
    chk(prog_cnt - p, 1);
    store_mode_i <= 1'b0;
  endtask

  task automatic t_local();
    logic [31:0] a;
    a = 32'h7FFF_FFF0;
    can_mode_i <= 1'b1;
    @(posedge clk_i);
    xact(CMD_ARITHMETIC_WITH_CONSTANT, OP_LOAD, 8'h00, a, 1'b1);
    chk_rep(ST_OK, CMD_ARITHMETIC_WITH_CONSTANT, a);
    chk(tx_can_id_o, reply_addr_i);
    xact(CMD_ARITHMETIC_WITH_CONSTANT, OP_ADD, 8'h00, 32'h5, 1'b1);
    chk(accu_o, a + 32'h5);
    xact(CMD_ARITHMETIC_WITH_X_REGISTER, OP_TO_X, 8'h00, 32'h0, 1'b1);
    chk(xreg_o, a + 32'h5);
    xact(CMD_COMPARE, 8'h00, 8'h00, a + 32'h5, 1'b1);
    chk({flag_zero_o, flag_neg_o}, 2'b10);
    xact(CMD_COMPARE, 8'h00, 8'h00, a + 32'h6, 1'b1);
    chk({flag_zero_o, flag_neg_o}, 2'b01);
    xact(CMD_ACC_AXIS, 8'h00, 8'h00, 32'h9, 1'b1);
    chk(ex_seen.value, a + 32'h5);
    chk_rep(ST_OK, CMD_ACC_AXIS, 32'h9);
    err_set_i <= 4'hA;
    @(posedge clk_i);
    err_set_i <= 4'h0;
    @(posedge clk_i);
    chk(err_flags_o, 4'hA);
    xact(CMD_CLR_ERR, 8'h01, 8'h00, 32'h0, 1'b1);
    chk(err_flags_o, 4'h8);
    can_mode_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic t_addr();
    int seen;
    seen = 0;
    addr_sel = MY_ADDR + 8'h01;
    xact(CMD_RD_AXIS, 8'h00, 8'h00, 32'h0, 1'b0);
    repeat (20)
    begin
      @(posedge clk_i);
      seen += int'(tx_valid_o !== 1'b0);
    end
    chk(seen, 0);
    addr_sel = MY_ADDR;
    xact(CMD_RD_AXIS, 8'h01, 8'h00, 32'h0, 1'b1);
    chk_rep(ST_OK, CMD_RD_AXIS, be_res.value);
  endtask

  initial
  begin
    srst_i        = 1'b1;
    can_mode_i    = 1'b0;
    store_mode_i  = 1'b0;
    cfg_lock_i    = 1'b0;
    module_addr_i = MY_ADDR;
    reply_addr_i  = 8'h02;
    addr_sel      = MY_ADDR;
    sum_err       = 8'h00;
    err_set_i     = 4'h0;
    exec_done_i   = 1'b0;
    be_res        = '{ST_OK, 32'h8123_4567};
    be_lat        = 0;
    be_cnt        = 0;
    prog_cnt      = 0;
    error_cnt     = 0;
    checked       = 0;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_backend();
    t_errors();
    t_store();
    t_local();
    t_addr();
    report_and_stop();
  end
endmodule

bind mcr_engine mcr_engine_monitor u_mcr_engine_monitor (
  .clk_i(clk_i), .srst_i(srst_i), .module_addr_i(module_addr_i),
  .reply_addr_i(reply_addr_i), .can_mode_i(can_mode_i), .rx_ready_o(rx_ready_o),
  .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i),
  .exec_valid_o(exec_valid_o), .exec_done_i(exec_done_i));
`default_nettype wire
